// ===== verilog/host_serial_pkg.sv
// How it works
// - select 00 rx, 01 both, 10 tx, 11 off
// - transmitter enable high, receiver enable low
// - host never pulls red mode pin low
// - host configures line type before using select
// - both sides pause while flow line withholds
// - no flow wiring means device ignores CTS
// - DSR assertion requests a wireless connect
// - DTR asserted only once startup is done
// - link indicator low while linked, pulses on data
// - green pin input at startup, output after
// - low green strap restores serial settings
// - both straps low restores factory settings
// - host holds strap stable first 500 ms
// - strap pulled high internally when undriven
// - low connect switch requests connect function
// - open connect switch reads inactive via pull-up; the host drives switch0N high instead, no pull-up here
// - host reset output only pulls low
// - open reset input reads as deasserted
package host_serial_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned STRAP_STABLE_MS = 500;
  localparam int unsigned STARTUP_MS      = 2000;
  localparam int unsigned BLINK_US        = 50_000;
  localparam int unsigned STRAP_CYCLES    = (CLK_HZ / 1000) * STRAP_STABLE_MS;
  localparam int unsigned STARTUP_CYCLES  = (CLK_HZ / 1000) * STARTUP_MS;
  localparam int unsigned BLINK_CYCLES    = (CLK_HZ / 1_000_000) * BLINK_US;

  typedef enum logic [1:0] {
    SEL_RX_ONLY = 2'h0,
    SEL_BOTH    = 2'h1,
    SEL_TX_ONLY = 2'h2,
    SEL_OFF     = 2'h3
  } xcvr_sel_t;

  typedef enum logic [1:0] {
    LINE_LOGIC = 2'h0,
    LINE_RS232 = 2'h1,
    LINE_RS422 = 2'h2,
    LINE_RS485 = 2'h3
  } line_type_t;

  typedef enum logic [1:0] {
    RESTORE_NONE    = 2'h0,
    RESTORE_SERIAL  = 2'h1,
    RESTORE_FACTORY = 2'h2
  } restore_t;
endpackage

// ===== verilog/host_serial_if.sv
`timescale 1ns/1ps
interface host_serial_if;
  logic ctsN;
  logic rtsN;
  logic dsrN;
  logic dtrN;
  logic linkLedN;
  logic greenOut;
  logic greenOe;
  logic greenHostOut;
  logic greenHostOe;
  logic redModeN;
  logic switch0N;
  logic resetHostOut;
  logic resetHostOe;
  logic xcvr_sel_bit0;
  logic xcvr_sel_bit1;
  wire  greenPin = greenOe ? greenOut : (greenHostOe ? greenHostOut : 1'b1);
  wire  resetPinN = resetHostOe ? resetHostOut : 1'b1;

  modport device (input ctsN, dsrN, switch0N, greenPin, resetPinN, redModeN,
                  output rtsN, dtrN, linkLedN, greenOut, greenOe,
                  xcvr_sel_bit0, xcvr_sel_bit1);
  modport host (output ctsN, dsrN, switch0N, greenHostOut, greenHostOe,
                resetHostOut, resetHostOe, redModeN,
                input rtsN, dtrN, linkLedN, greenPin, xcvr_sel_bit0, xcvr_sel_bit1);
endinterface

// ===== verilog/adapter_device.sv
`timescale 1ns/1ps
module adapter_device
  import host_serial_pkg::*;
#(
  parameter int unsigned STRAP_CNT   = STRAP_CYCLES,
  parameter int unsigned STARTUP_CNT = STARTUP_CYCLES,
  parameter int unsigned BLINK_CNT   = BLINK_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  host_serial_if.device    link,
  input  wire logic        flowEnable,
  input  wire line_type_t  lineType,
  input  wire xcvr_sel_t   selRequest,
  input  wire logic        linkUp,
  input  wire logic        dataActivity,
  input  wire logic        greenStatus,
  input  wire logic        rxRoom,
  input  wire logic        txPending,
  output logic             txAllowed,
  output logic             connectRequest,
  output logic             connectSwitchReq,
  output logic             restoreValid,
  output restore_t         restoreKind,
  output logic             deviceReady,
  output logic             resetActive
);
  // refuse counts the startup sequence cannot order or hold
  if (STRAP_CNT < 1) begin : g_bad_strap
    $error("adapter_device: strap window must last at least one cycle");
  end
  if (STARTUP_CNT <= STRAP_CNT) begin : g_bad_startup
    $error("adapter_device: startup must end after strap capture");
  end
  if (BLINK_CNT < 1 || BLINK_CNT > 32'h7FFF_FFFF) begin : g_bad_blink
    $error("adapter_device: blink time out of range");
  end

  // positions of the pins in the synchroniser word
  localparam int unsigned SYNC_W       = 5;
  localparam int unsigned POS_CTS      = 0;
  localparam int unsigned POS_DSR      = 1;
  localparam int unsigned POS_SWITCH   = 2;
  localparam int unsigned POS_STRAP    = 3;
  localparam int unsigned POS_RESET    = 4;
  localparam int unsigned STRAP_LAST   = STRAP_CNT - 1;
  localparam int unsigned STARTUP_LAST = STARTUP_CNT - 1;

  logic [31:0] startCntQ;
  logic [31:0] blinkCntQ;
  logic        strapDoneQ;
  logic        upQ;
  logic        resetSyncN;
  logic        ctsOkN;
  logic        dsrN;
  logic        sw0N;
  logic        strapN;
  logic        captureNow;
  logic        startupEnd;
  logic        blinkDark;
  restore_t    restoreKindD;
  xcvr_sel_t   selD;

  // two-flop synchronisers for cts, dsr, switch0, green strap, reset pin
  logic [SYNC_W-1:0] inRawD;
  logic [SYNC_W-1:0] sync1Q;
  logic [SYNC_W-1:0] sync2Q;
  assign inRawD = {link.resetPinN, link.greenPin, link.switch0N, link.dsrN, link.ctsN};
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sync1Q <= 5'h1F;
      sync2Q <= 5'h1F;
    end else begin
      sync1Q <= inRawD;
      sync2Q <= sync1Q;
    end
  end
  assign ctsOkN      = sync2Q[POS_CTS];
  assign dsrN        = sync2Q[POS_DSR];
  assign sw0N        = sync2Q[POS_SWITCH];
  assign strapN      = sync2Q[POS_STRAP];
  assign resetSyncN  = sync2Q[POS_RESET];
  assign resetActive = !resetSyncN;
  assign captureNow  = !strapDoneQ && (startCntQ == 32'(STRAP_LAST));
  assign startupEnd  = (startCntQ == 32'(STARTUP_LAST));
  assign blinkDark   = (blinkCntQ > 32'(BLINK_CNT));

  // startup counter, restarted by pin reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !resetSyncN) begin
      startCntQ <= 32'h0;
    end else if (startCntQ < STARTUP_CNT) begin
      startCntQ <= startCntQ + 32'h1;
    end
  end

  // strap capture once at end of stability window
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !resetSyncN) begin
      strapDoneQ   <= 1'b0;
      restoreValid <= 1'b0;
      restoreKind  <= RESTORE_NONE;
    end else if (captureNow) begin
      strapDoneQ   <= 1'b1;
      restoreValid <= 1'b1;
      restoreKind  <= restoreKindD;
    end
  end

  // factory restore wins when both straps are low
  always_comb begin
    restoreKindD = RESTORE_NONE;
    if (!strapN && !sw0N) begin
      restoreKindD = RESTORE_FACTORY;
    end else if (!strapN) begin
      restoreKindD = RESTORE_SERIAL;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n || !resetSyncN) begin
      upQ <= 1'b0;
    end else if (startupEnd) begin
      upQ <= 1'b1;
    end
  end
  assign deviceReady = upQ;

  always_ff @(posedge clk_sys) begin
    if (!reset_n || !resetSyncN) begin
      link.dtrN <= 1'b1;
    end else begin
      link.dtrN <= !upQ;
    end
  end

  // flow line withholds until ready and there is room
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !resetSyncN) begin
      link.rtsN <= 1'b1;
    end else begin
      link.rtsN <= !(upQ && rxRoom);
    end
  end

  assign txAllowed = upQ && txPending && (!flowEnable || !ctsOkN);

  always_ff @(posedge clk_sys) begin
    if (!reset_n || !resetSyncN) begin
      connectRequest   <= 1'b0;
      connectSwitchReq <= 1'b0;
    end else begin
      connectRequest   <= upQ && !dsrN;
      connectSwitchReq <= upQ && !sw0N;
    end
  end

  // link indicator with activity blink
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !resetSyncN) begin
      blinkCntQ <= 32'h0;
    end else if (dataActivity && blinkCntQ == 32'h0) begin
      blinkCntQ <= 32'(2 * BLINK_CNT);
    end else if (blinkCntQ != 32'h0) begin
      blinkCntQ <= blinkCntQ - 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n || !resetSyncN) begin
      link.linkLedN <= 1'b1;
    end else if (blinkDark) begin
      link.linkLedN <= 1'b1;
    end else begin
      link.linkLedN <= !linkUp;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n || !resetSyncN) begin
      link.greenOe  <= 1'b0;
      link.greenOut <= 1'b1;
    end else begin
      link.greenOe  <= upQ;
      link.greenOut <= greenStatus;
    end
  end

  // select bits only meaningful for RS422/485 line types, off otherwise
  always_comb begin
    selD = SEL_OFF;
    case (lineType)
      LINE_RS422, LINE_RS485: begin
        if (upQ) begin
          selD = selRequest;
        end
      end
      default: begin
        selD = SEL_OFF;
      end
    endcase
  end

  // pin pair carries the select value with bit0 as its upper bit
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !resetSyncN) begin
      link.xcvr_sel_bit0 <= 1'b1;
      link.xcvr_sel_bit1 <= 1'b1;
    end else begin
      link.xcvr_sel_bit0 <= selD[1];
      link.xcvr_sel_bit1 <= selD[0];
    end
  end
endmodule

// ===== verilog/adapter_host.sv
`timescale 1ns/1ps
module adapter_host
  import host_serial_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire logic     reset_n,
  host_serial_if.host   link,
  input  wire logic     hostRxRoom,
  input  wire logic     hostTxPending,
  input  wire logic     connectCmd,
  input  wire logic     restoreSwitch,
  input  wire logic     connectSwitch,
  input  wire logic     resetCmd,
  output logic          hostTxAllowed,
  output logic          deviceReady,
  output logic          linkActive,
  output logic          greenSeen,
  output logic          txEnable,
  output logic          rxEnableN
);
  logic [4:0] s1Q, s2Q;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s1Q <= 5'h1F;
      s2Q <= 5'h1F;
    end else begin
      s1Q <= {link.xcvr_sel_bit1, link.xcvr_sel_bit0, link.greenPin, link.linkLedN,
              link.rtsN};
      s2Q <= s1Q;
    end
  end

  assign hostTxAllowed = hostTxPending && !s2Q[0];
  assign linkActive    = !s2Q[1];
  assign greenSeen     = s2Q[2];
  assign deviceReady   = !link.dtrN;

  // decode of select pair into transceiver enables
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      txEnable  <= 1'b0;
      rxEnableN <= 1'b1;
    end else begin
      txEnable  <= s2Q[3] ^ s2Q[4];
      rxEnableN <= s2Q[3];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      link.ctsN         <= 1'b1;
      link.dsrN         <= 1'b1;
      link.switch0N     <= 1'b1;
      link.greenHostOut <= 1'b0;
      link.greenHostOe  <= 1'b0;
      link.resetHostOut <= 1'b0;
      link.resetHostOe  <= 1'b0;
      link.redModeN     <= 1'b1;
    end else begin
      link.ctsN         <= !hostRxRoom;
      link.dsrN         <= !connectCmd;
      link.switch0N     <= !connectSwitch;
      link.greenHostOut <= 1'b0;
      link.greenHostOe  <= restoreSwitch;
      link.resetHostOut <= 1'b0;
      link.resetHostOe  <= resetCmd;
      link.redModeN     <= 1'b1;
    end
  end
endmodule

// ===== bench/host_serial_assertions.sv
`timescale 1ns/1ps
module host_serial_assertions #(
  parameter int unsigned STARTUP_CNT = 50
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic dtrN,
  input wire logic greenOe,
  input wire logic greenHostOe,
  input wire logic greenHostOut,
  input wire logic resetHostOe,
  input wire logic resetHostOut,
  input wire logic resetPinN,
  input wire logic redModeN,
  input wire logic xcvr_sel_bit0,
  input wire logic xcvr_sel_bit1
);
  int unsigned cntQ;

  // cycles since reset release, saturating
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cntQ <= 0;
    end else if (cntQ < 1000) begin
      cntQ <= cntQ + 1;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_dtr_after_start: assert property (!dtrN |-> cntQ >= STARTUP_CNT)
    else $error("ready flag before startup time");
  a_green_after_start: assert property (greenOe |-> cntQ >= STARTUP_CNT)
    else $error("green pin driven before startup time");
  a_green_dtr_pair: assert property (greenOe == !dtrN)
    else $error("green drive and ready flag disagree");
  a_sel_off_early: assert property (dtrN |-> {xcvr_sel_bit0, xcvr_sel_bit1} == 2'h3)
    else $error("select bits active before ready");
  a_dtr_stays_low: assert property (resetPinN[*4] ##0 !dtrN |=> !dtrN)
    else $error("ready flag dropped without reset");
  a_red_kept_high: assert property (redModeN)
    else $error("red mode pin pulled low");
  a_reset_open_drain: assert property (resetHostOe |-> !resetHostOut)
    else $error("reset pin driven high");
  a_strap_pulls_low: assert property (greenHostOe |-> !greenHostOut)
    else $error("strap driven high by host");

  cover property ($fell(dtrN));
  cover property ({xcvr_sel_bit0, xcvr_sel_bit1} == 2'h1);
  cover property (resetHostOe);
endmodule

// ===== bench/tb_host_serial_control_straps.sv
`timescale 1ns/1ps
module tb_host_serial_control_straps;
  import host_serial_pkg::*;
  logic       clk_sys, reset_n, flowEnable, linkUp, dataActivity, rxRoom, txPending;
  logic       hostRxRoom, connectCmd, restoreSwitch, connectSwitch, resetCmd;
  logic       txAllowed, connectRequest, connectSwitchReq, restoreValid, devReady;
  logic       resetActive, hostTxAllowed, hostReady, linkActive, txEnable, rxEnableN;
  logic       greenStatus, greenSeen;
  line_type_t lineType;
  xcvr_sel_t  selRequest;
  restore_t   restoreKind;
  int         mismatches, cmp_count;

  host_serial_if link();
  adapter_device #(.STRAP_CNT(20), .STARTUP_CNT(50), .BLINK_CNT(4)) adapter_device_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .link(link), .flowEnable(flowEnable),
    .lineType(lineType), .selRequest(selRequest), .linkUp(linkUp),
    .dataActivity(dataActivity), .greenStatus(greenStatus), .rxRoom(rxRoom),
    .txPending(txPending), .txAllowed(txAllowed), .connectRequest(connectRequest),
    .connectSwitchReq(connectSwitchReq), .restoreValid(restoreValid),
    .restoreKind(restoreKind), .deviceReady(devReady), .resetActive(resetActive));
  adapter_host adapter_host_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .link(link), .hostRxRoom(hostRxRoom),
    .hostTxPending(1'b1), .connectCmd(connectCmd), .restoreSwitch(restoreSwitch),
    .connectSwitch(connectSwitch), .resetCmd(resetCmd), .hostTxAllowed(hostTxAllowed),
    .deviceReady(hostReady), .linkActive(linkActive), .greenSeen(greenSeen),
    .txEnable(txEnable), .rxEnableN(rxEnableN));
  host_serial_assertions #(.STARTUP_CNT(50)) host_serial_assertions_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .dtrN(link.dtrN), .greenOe(link.greenOe),
    .greenHostOe(link.greenHostOe), .greenHostOut(link.greenHostOut),
    .resetHostOe(link.resetHostOe), .resetHostOut(link.resetHostOut),
    .resetPinN(link.resetPinN), .redModeN(link.redModeN),
    .xcvr_sel_bit0(link.xcvr_sel_bit0), .xcvr_sel_bit1(link.xcvr_sel_bit1));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask

  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (devReady !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      wrap_up();
    end
  endtask

  task automatic strap_case(input logic rs, input logic sw);
    restore_t k;
    k = (rs && sw) ? RESTORE_FACTORY : (rs ? RESTORE_SERIAL : RESTORE_NONE);
    restoreSwitch = rs;
    connectSwitch = sw;
    reset_n = 1'b0;
    tick(8);
    reset_n = 1'b1;
    tick(4);
    chk("early", 2'h0, {restoreValid, connectSwitchReq});
    chk("strap seen", {1'b0, !rs}, {1'b0, greenSeen});
    tick(24);
    chk("restoreValid", 2'h1, {1'b0, restoreValid});
    chk("restoreKind", k, restoreKind);
    wait_ready();
    tick(5);
    chk("ready", {1'b1, sw}, {hostReady, connectSwitchReq});
    restoreSwitch = 1'b0;
    connectSwitch = 1'b0;
  endtask

  task automatic sel_sweep();
    logic [1:0] e;
    for (int lt = 0; lt < 4; lt++) begin
      for (int s = 0; s < 4; s++) begin
        lineType = line_type_t'(lt);
        selRequest = xcvr_sel_t'(s);
        tick(6);
        e = (lt >= 2) ? 2'(s) : 2'h3;
        chk("sel pins", e, {link.xcvr_sel_bit0, link.xcvr_sel_bit1});
        chk("xcvr enables", {e[1] ^ e[0], e[1]}, {txEnable, rxEnableN});
      end
    end
  endtask

  task automatic flow_case(input logic fe, input logic room, input logic exp);
    flowEnable = fe;
    hostRxRoom = room;
    rxRoom = room;
    tick(6);
    chk("flow", {exp, room}, {txAllowed, hostTxAllowed});
  endtask

  task automatic link_case();
    int n;
    connectCmd = 1'b1;
    linkUp = 1'b1;
    tick(6);
    chk("connect", 2'h3, {connectRequest, linkActive});
    dataActivity = 1'b1;
    tick(1);
    dataActivity = 1'b0;
    n = 0;
    while (linkActive !== 1'b0 && n < 10) begin
      tick(1);
      n++;
    end
    chk("blink", 2'h0, {1'b0, linkActive});
    connectCmd = 1'b0;
    tick(20);
    chk("link held", 2'h1, {connectRequest, linkActive});
  endtask

  task automatic green_case();
    greenStatus = 1'b0;
    tick(6);
    chk("green pin", 2'h2, {hostReady, greenSeen});
    greenStatus = 1'b1;
    tick(6);
    chk("green pin", 2'h3, {hostReady, greenSeen});
  endtask

  task automatic pin_reset();
    resetCmd = 1'b1;
    tick(5);
    chk("pin reset", 2'h1, {devReady, resetActive});
    resetCmd = 1'b0;
    tick(1);
    wait_ready();
    tick(5);
    chk("ready again", 2'h3, {devReady, hostReady});
  endtask

  initial begin
    {reset_n, flowEnable, linkUp, dataActivity, rxRoom, txPending} = 6'h03;
    {hostRxRoom, connectCmd, restoreSwitch, connectSwitch, resetCmd} = 5'h10;
    lineType = LINE_LOGIC;
    selRequest = SEL_OFF;
    greenStatus = 1'b1;
    mismatches = 0;
    cmp_count = 0;
    for (int i = 0; i < 4; i++) begin
      strap_case(i[1], i[0]);
    end
    sel_sweep();
    flow_case(1'b1, 1'b0, 1'b0);
    flow_case(1'b1, 1'b1, 1'b1);
    flow_case(1'b0, 1'b0, 1'b1);
    link_case();
    green_case();
    pin_reset();
    wrap_up();
  end
endmodule
